//--- hw/rprc_ctrl.sv
// What this block does
// (R1) after transmit or timeout, return to standby
// (R2) transmit timeout armed only for nonzero low count byte
// (R3) clear exactly the flags set in mask
// (R4) event pin is OR of enabled mapped flags
// (R5) receive count zero: single receive, no timeout
// (R6) receive count all ones: continuous receive
// (R7) other counts: timer, stopped on packet detection
// (R8) receive done raised regardless of packet validity
// (R9) separate receive event flags plus timeout flag
// (R10) packet status returns snr times four
// (R11) buffer status returns length and start offset
// (R12) signed 20-bit frequency error in three registers
// (R13) frequency error sign flips with inverted iq
// (R14) host avoids high spreading factors, narrow bandwidths
// (R15) responder address in four bytes, msb first
// (R16) match width field selects 8 to 32 bits
// (R17) responder answers only matching ranging requests
// (R18) initiator target address in four byte registers
// (R19) initiator and responder ranging event flags
// (R20) host configures both ranging ends identically
// (R21) carrier argument is synthesizer step count
// (R22) 16-bit ranging delay calibration in two registers
// (R23) timeout equals step length times count (receive) or its low byte (transmit)
`timescale 1ns/1ps

module rprc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic in_valid_i,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic in_ready_o,
    output logic out_valid_o,
    output logic [WIDTH-1:0] out_data_o,
    input wire logic out_ready_i
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] rd_ptr;
        logic [AW-1:0] wr_ptr;
        logic [AW:0] count;
    } fifo_state_s;

    fifo_state_s st;
    fifo_state_s next_st;
    logic push;
    logic pop;

    always_comb
    begin
        next_st = st;
        push = in_valid_i && (st.count != (AW+1)'(DEPTH));
        pop = out_ready_i && (st.count != '0);
        if (push)
        begin
            next_st.mem[st.wr_ptr] = in_data_i;
            next_st.wr_ptr = (st.wr_ptr == AW'(DEPTH - 1)) ? '0 : st.wr_ptr + 1'b1;
        end
        if (pop)
            next_st.rd_ptr = (st.rd_ptr == AW'(DEPTH - 1)) ? '0 : st.rd_ptr + 1'b1;
        if (push && !pop)
            next_st.count = st.count + 1'b1;
        else if (pop && !push)
            next_st.count = st.count - 1'b1;
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i)
            st <= '0;
        else if (ce_i)
            st <= next_st;
    end

    assign in_ready_o = (st.count != (AW+1)'(DEPTH));
    assign out_valid_o = (st.count != '0);
    assign out_data_o = st.mem[st.rd_ptr];
endmodule

module rprc_ctrl
    import rprc_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic cmd_valid_i,
    input wire rprc_cmd_s cmd_i,
    output logic cmd_ready_o,
    output logic rsp_valid_o,
    output logic [31:0] rsp_data_o,
    input wire logic tick_i,
    input wire logic tx_last_bit_i,
    input wire logic rx_preamble_i,
    input wire logic rx_sync_i,
    input wire logic rx_header_ok_i,
    input wire logic rx_header_bad_i,
    input wire logic rx_packet_i,
    input wire logic rx_checksum_bad_i,
    input wire rprc_rx_info_s rx_info_i,
    input wire logic rng_req_valid_i,
    input wire logic [31:0] rng_req_addr_i,
    input wire logic init_result_ok_i,
    input wire logic init_timeout_i,
    input wire logic reply_done_i,
    input wire logic rx_data_valid_i,
    input wire logic [FIFO_WIDTH-1:0] rx_data_i,
    output logic rx_data_ready_o,
    output logic buf_valid_o,
    output logic [FIFO_WIDTH-1:0] buf_data_o,
    input wire logic buf_ready_i,
    output rprc_mode_e mode_o,
    output logic [EVENT_PINS-1:0] event_pin_o,
    output logic [EV_W-1:0] event_flags_o,
    output logic [23:0] carrier_freq_o,
    output logic [23:0] modulation_o,
    output logic [31:0] target_addr_o,
    output logic [15:0] range_cal_o,
    output logic iq_invert_o,
    output logic initiator_o,
    output logic reply_start_o
);
    rprc_state_s st;
    rprc_state_s next_st;
    logic [EV_W-1:0] set_bits;
    logic [EV_W-1:0] clr_bits;
    logic [31:0] match_mask;
    logic [11:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic [7:0] step_load;
    logic timer_expire;
    logic [15:0] cmd_count;
    logic [19:0] fei_signed;

    rprc_fifo #(
        .WIDTH(FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_rx_fifo (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .ce_i(ce_i),
        .in_valid_i(rx_data_valid_i),
        .in_data_i(rx_data_i),
        .in_ready_o(rx_data_ready_o),
        .out_valid_o(buf_valid_o),
        .out_data_o(buf_data_o),
        .out_ready_i(buf_ready_i)
    );

    always_comb
    begin
        reg_addr = cmd_i.arg[27:16];
        reg_wdata = cmd_i.arg[7:0];
        cmd_count = cmd_i.arg[15:0];
        case (cmd_i.arg[17:16])
            2'h0: step_load = STEP_TICKS_0;
            2'h1: step_load = STEP_TICKS_1;
            2'h2: step_load = STEP_TICKS_2;
            default: step_load = STEP_TICKS_3;
        endcase
        case (st.address_match_width[MATCH_FIELD_HI:MATCH_FIELD_LO])
            MATCH_8: match_mask = MASK_8; // see (R16)
            MATCH_16: match_mask = MASK_16;
            MATCH_24: match_mask = MASK_24;
            default: match_mask = MASK_32;
        endcase
        // register readback, unmapped addresses read zero
        case (reg_addr)
            REG_TARGET_ADDRESS_B3: reg_rdata = st.initiator_target_address[31:24];
            REG_TARGET_ADDRESS_B2: reg_rdata = st.initiator_target_address[23:16];
            REG_TARGET_ADDRESS_B1: reg_rdata = st.initiator_target_address[15:8];
            REG_TARGET_ADDRESS_B0: reg_rdata = st.initiator_target_address[7:0];
            REG_OWN_ADDRESS_B3: reg_rdata = st.responder_own_address[31:24];
            REG_OWN_ADDRESS_B2: reg_rdata = st.responder_own_address[23:16];
            REG_OWN_ADDRESS_B1: reg_rdata = st.responder_own_address[15:8];
            REG_OWN_ADDRESS_B0: reg_rdata = st.responder_own_address[7:0];
            REG_RANGE_CAL_HIGH: reg_rdata = st.range_cal[15:8];
            REG_RANGE_CAL_LOW: reg_rdata = st.range_cal[7:0];
            REG_ADDRESS_MATCH_WIDTH: reg_rdata = st.address_match_width;
            REG_FREQ_ERROR_HIGH: reg_rdata = {4'h0, st.frequency_error_estimate[19:16]}; // see (R12)
            REG_FREQ_ERROR_MID: reg_rdata = st.frequency_error_estimate[15:8];
            REG_FREQ_ERROR_LOW: reg_rdata = st.frequency_error_estimate[7:0];
            default: reg_rdata = 8'h00;
        endcase
        // timer: prescale counts ticks of one step, remain counts steps
        timer_expire = st.timer_on && tick_i && (st.prescale == 8'h00)
            && (st.remain == 16'h0001); // see (R23)
        fei_signed = st.iq_invert ? 20'(-rx_info_i.freq_error_raw) // see (R13)
            : rx_info_i.freq_error_raw;

        next_st = st;
        next_st.rsp_valid = 1'b0;
        next_st.reply_start = 1'b0;
        set_bits = '0;
        clr_bits = '0;

        if (st.timer_on && tick_i)
        begin
            if (st.prescale == 8'h00)
            begin
                next_st.prescale = st.prescale_load - 8'h01;
                next_st.remain = st.remain - 16'h0001;
            end
            else
                next_st.prescale = st.prescale - 8'h01;
        end

        case (st.mode)
            transmit_state:
            begin
                if (tx_last_bit_i)
                begin
                    set_bits[EV_TX_DONE] = 1'b1;
                    next_st.mode = rc_standby_state; // see (R1)
                    next_st.timer_on = 1'b0;
                end
                else if (timer_expire)
                begin
                    set_bits[EV_TIMEOUT] = 1'b1; // see (R2)
                    next_st.mode = rc_standby_state; // see (R1)
                    next_st.timer_on = 1'b0;
                end
                if (init_result_ok_i)
                    set_bits[EV_INIT_OK] = 1'b1; // see (R19)
                if (init_timeout_i)
                    set_bits[EV_INIT_TIMEOUT] = 1'b1;
            end
            receive_state:
            begin
                set_bits[EV_PREAMBLE] = rx_preamble_i; // see (R9)
                set_bits[EV_SYNC] = rx_sync_i;
                set_bits[EV_HEADER_OK] = rx_header_ok_i;
                set_bits[EV_HEADER_BAD] = rx_header_bad_i;
                set_bits[EV_CHECKSUM] = rx_checksum_bad_i;
                set_bits[EV_REPLY_DONE] = reply_done_i; // see (R19)
                if (rx_preamble_i || rx_sync_i || rx_header_ok_i || rx_packet_i)
                begin
                    next_st.timer_on = 1'b0; // see (R7)
                end
                if (rx_packet_i)
                begin
                    set_bits[EV_RX_DONE] = 1'b1; // see (R8)
                    next_st.snr = rx_info_i.packet_snr_estimate;
                    next_st.length = rx_info_i.length;
                    next_st.start_offset = rx_info_i.start_offset;
                    next_st.frequency_error_estimate = fei_signed;
                    if (!st.rx_continuous)
                        next_st.mode = rc_standby_state; // see (R5) (R7)
                end
                else if (timer_expire && !rx_preamble_i && !rx_sync_i && !rx_header_ok_i)
                begin
                    set_bits[EV_TIMEOUT] = 1'b1; // see (R9)
                    next_st.mode = rc_standby_state; // see (R7)
                    next_st.timer_on = 1'b0;
                end
                if (rng_req_valid_i && !st.initiator)
                begin
                    if (((rng_req_addr_i ^ st.responder_own_address) & match_mask) == '0)
                        next_st.reply_start = 1'b1; // see (R17)
                    else
                        set_bits[EV_REJECT] = 1'b1; // see (R17) (R19)
                end
            end
            default:
            begin
                next_st.timer_on = 1'b0;
            end
        endcase

        if (cmd_valid_i)
        begin
            case (cmd_i.op)
                CMD_STANDBY:
                begin
                    next_st.mode = rc_standby_state;
                    next_st.timer_on = 1'b0;
                end
                CMD_START_TRANSMIT:
                begin
                    next_st.mode = transmit_state;
                    next_st.rx_continuous = 1'b0;
                    next_st.timer_on = (cmd_count[7:0] != 8'h00); // see (R2)
                    next_st.remain = {8'h00, cmd_count[7:0]}; // see (R23)
                    next_st.prescale = step_load - 8'h01;
                    next_st.prescale_load = step_load;
                end
                CMD_START_RECEIVE:
                begin
                    next_st.mode = receive_state;
                    next_st.rx_continuous = (cmd_count == RX_COUNT_CONTINUOUS); // see (R6)
                    next_st.timer_on = (cmd_count != RX_COUNT_SINGLE) // see (R5)
                        && (cmd_count != RX_COUNT_CONTINUOUS); // see (R7)
                    next_st.remain = cmd_count; // see (R23)
                    next_st.prescale = step_load - 8'h01;
                    next_st.prescale_load = step_load;
                end
                CMD_CLEAR_EVENTS: clr_bits = cmd_i.arg[EV_W-1:0]; // see (R3)
                CMD_EVENT_ROUTING:
                begin
                    case (cmd_i.arg[17:16])
                        2'h0: next_st.enable = cmd_i.arg[EV_W-1:0];
                        2'h1: next_st.pin_mask[0] = cmd_i.arg[EV_W-1:0];
                        2'h2: next_st.pin_mask[1] = cmd_i.arg[EV_W-1:0];
                        default: next_st.pin_mask[2] = cmd_i.arg[EV_W-1:0];
                    endcase
                end
                CMD_PACKET_STATUS:
                begin
                    next_st.rsp_valid = 1'b1;
                    next_st.rsp_data = {24'h000000, st.snr}; // see (R10)
                end
                CMD_BUFFER_STATUS:
                begin
                    next_st.rsp_valid = 1'b1;
                    next_st.rsp_data = {16'h0000, st.length, st.start_offset}; // see (R11)
                end
                CMD_CARRIER_FREQ: next_st.carrier_freq = cmd_i.arg[23:0]; // see (R21)
                CMD_MODULATION: next_st.modulation = cmd_i.arg[23:0];
                CMD_WRITE_REG:
                begin
                    case (reg_addr)
                        REG_TARGET_ADDRESS_B3: next_st.initiator_target_address[31:24] = reg_wdata; // see (R18)
                        REG_TARGET_ADDRESS_B2: next_st.initiator_target_address[23:16] = reg_wdata;
                        REG_TARGET_ADDRESS_B1: next_st.initiator_target_address[15:8] = reg_wdata;
                        REG_TARGET_ADDRESS_B0: next_st.initiator_target_address[7:0] = reg_wdata;
                        REG_OWN_ADDRESS_B3: next_st.responder_own_address[31:24] = reg_wdata; // see (R15)
                        REG_OWN_ADDRESS_B2: next_st.responder_own_address[23:16] = reg_wdata;
                        REG_OWN_ADDRESS_B1: next_st.responder_own_address[15:8] = reg_wdata;
                        REG_OWN_ADDRESS_B0: next_st.responder_own_address[7:0] = reg_wdata;
                        REG_RANGE_CAL_HIGH: next_st.range_cal[15:8] = reg_wdata; // see (R22)
                        REG_RANGE_CAL_LOW: next_st.range_cal[7:0] = reg_wdata;
                        REG_ADDRESS_MATCH_WIDTH: next_st.address_match_width = reg_wdata; // see (R16)
                        default: next_st.address_match_width = st.address_match_width;
                    endcase
                end
                CMD_READ_REG:
                begin
                    next_st.rsp_valid = 1'b1;
                    next_st.rsp_data = {24'h000000, reg_rdata};
                end
                CMD_IQ_INVERT: next_st.iq_invert = cmd_i.arg[0];
                CMD_RANGING_ROLE: next_st.initiator = cmd_i.arg[0];
                default: next_st.rsp_valid = 1'b0;
            endcase
        end

        // a set in the same cycle as its clear wins
        next_st.flags = (st.flags & ~clr_bits) | set_bits; // see (R3)
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i)
            st <= RPRC_STATE_RESET;
        else if (ce_i)
            st <= next_st;
    end

    for (genvar p = 0; p < EVENT_PINS; p++)
    begin : g_pin
        assign event_pin_o[p] = |(st.flags & st.enable & st.pin_mask[p]); // see (R4)
    end

    assign cmd_ready_o = 1'b1;
    assign rsp_valid_o = st.rsp_valid;
    assign rsp_data_o = st.rsp_data;
    assign mode_o = st.mode;
    assign event_flags_o = st.flags;
    assign carrier_freq_o = st.carrier_freq;
    assign modulation_o = st.modulation;
    assign target_addr_o = st.initiator_target_address;
    assign range_cal_o = st.range_cal;
    assign iq_invert_o = st.iq_invert;
    assign initiator_o = st.initiator;
    assign reply_start_o = st.reply_start;
endmodule

//--- hw/rprc_pkg.sv
package rprc_pkg;

    // register byte addresses
    localparam logic [11:0] REG_TARGET_ADDRESS_B3 = 12'h912;
    localparam logic [11:0] REG_TARGET_ADDRESS_B2 = 12'h913;
    localparam logic [11:0] REG_TARGET_ADDRESS_B1 = 12'h914;
    localparam logic [11:0] REG_TARGET_ADDRESS_B0 = 12'h915;
    localparam logic [11:0] REG_OWN_ADDRESS_B3 = 12'h916;
    localparam logic [11:0] REG_OWN_ADDRESS_B2 = 12'h917;
    localparam logic [11:0] REG_OWN_ADDRESS_B1 = 12'h918;
    localparam logic [11:0] REG_OWN_ADDRESS_B0 = 12'h919;
    localparam logic [11:0] REG_RANGE_CAL_HIGH = 12'h92C;
    localparam logic [11:0] REG_RANGE_CAL_LOW = 12'h92D;
    localparam logic [11:0] REG_ADDRESS_MATCH_WIDTH = 12'h931;
    localparam logic [11:0] REG_FREQ_ERROR_HIGH = 12'h954;
    localparam logic [11:0] REG_FREQ_ERROR_MID = 12'h955;
    localparam logic [11:0] REG_FREQ_ERROR_LOW = 12'h956;

    // address match width field
    localparam int MATCH_FIELD_HI = 7;
    localparam int MATCH_FIELD_LO = 6;
    localparam logic [1:0] MATCH_8 = 2'h0;
    localparam logic [1:0] MATCH_16 = 2'h1;
    localparam logic [1:0] MATCH_24 = 2'h2;
    localparam logic [31:0] MASK_8 = 32'h000000FF;
    localparam logic [31:0] MASK_16 = 32'h0000FFFF;
    localparam logic [31:0] MASK_24 = 32'h00FFFFFF;
    localparam logic [31:0] MASK_32 = 32'hFFFFFFFF;

    // event flag bit positions
    localparam int EV_W = 16;
    localparam int EV_TX_DONE = 0;
    localparam int EV_RX_DONE = 1;
    localparam int EV_SYNC = 2;
    localparam int EV_PREAMBLE = 3;
    localparam int EV_HEADER_OK = 4;
    localparam int EV_HEADER_BAD = 5;
    localparam int EV_CHECKSUM = 6;
    localparam int EV_TIMEOUT = 7;
    localparam int EV_INIT_OK = 8;
    localparam int EV_INIT_TIMEOUT = 9;
    localparam int EV_REPLY_DONE = 10;
    localparam int EV_REJECT = 11;
    localparam int EVENT_PINS = 3;

    // receive timeout special counts
    localparam logic [15:0] RX_COUNT_SINGLE = 16'h0000;
    localparam logic [15:0] RX_COUNT_CONTINUOUS = 16'hFFFF;

    // timebase ticks per timeout step
    localparam logic [7:0] STEP_TICKS_0 = 8'h01;
    localparam logic [7:0] STEP_TICKS_1 = 8'h04;
    localparam logic [7:0] STEP_TICKS_2 = 8'h10;
    localparam logic [7:0] STEP_TICKS_3 = 8'h40;

    // receive FIFO shape
    localparam int FIFO_WIDTH = 8;
    localparam int FIFO_DEPTH = 16;

    // command codes
    localparam logic [3:0] CMD_STANDBY = 4'h0;
    localparam logic [3:0] CMD_START_TRANSMIT = 4'h1;
    localparam logic [3:0] CMD_START_RECEIVE = 4'h2;
    localparam logic [3:0] CMD_CLEAR_EVENTS = 4'h3;
    localparam logic [3:0] CMD_EVENT_ROUTING = 4'h4;
    localparam logic [3:0] CMD_PACKET_STATUS = 4'h5;
    localparam logic [3:0] CMD_BUFFER_STATUS = 4'h6;
    localparam logic [3:0] CMD_CARRIER_FREQ = 4'h7;
    localparam logic [3:0] CMD_MODULATION = 4'h8;
    localparam logic [3:0] CMD_WRITE_REG = 4'h9;
    localparam logic [3:0] CMD_READ_REG = 4'hA;
    localparam logic [3:0] CMD_IQ_INVERT = 4'hB;
    localparam logic [3:0] CMD_RANGING_ROLE = 4'hC;

    typedef enum logic [2:0] {
        rc_standby_state = 3'b001,
        transmit_state = 3'b010,
        receive_state = 3'b100
    } rprc_mode_e;

    typedef struct packed {
        logic [3:0] op;
        logic [31:0] arg;
    } rprc_cmd_s;

    // per-packet report from the modem
    typedef struct packed {
        logic [7:0] packet_snr_estimate;
        logic [7:0] length;
        logic [7:0] start_offset;
        logic [19:0] freq_error_raw;
    } rprc_rx_info_s;

    typedef struct packed {
        rprc_mode_e mode;
        logic rx_continuous;
        logic timer_on;
        logic [15:0] remain;
        logic [7:0] prescale;
        logic [7:0] prescale_load;
        logic [EV_W-1:0] flags;
        logic [EV_W-1:0] enable;
        logic [EVENT_PINS-1:0][EV_W-1:0] pin_mask;
        logic [31:0] initiator_target_address;
        logic [31:0] responder_own_address;
        logic [7:0] address_match_width;
        logic [15:0] range_cal;
        logic [19:0] frequency_error_estimate;
        logic [7:0] snr;
        logic [7:0] length;
        logic [7:0] start_offset;
        logic [23:0] carrier_freq;
        logic [23:0] modulation;
        logic iq_invert;
        logic initiator;
        logic reply_start;
        logic rsp_valid;
        logic [31:0] rsp_data;
    } rprc_state_s;

    localparam rprc_state_s RPRC_STATE_RESET = '{mode: rc_standby_state, default: '0};

endpackage

//--- dv/rprc_ctrl_assertions.sv
`timescale 1ns/1ps
module rprc_ctrl_assertions
    import rprc_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic cmd_valid_i,
    input wire rprc_cmd_s cmd_i,
    input wire logic rsp_valid_o,
    input wire logic tx_last_bit_i,
    input wire logic rng_req_valid_i,
    input wire logic rx_data_ready_o,
    input wire logic buf_valid_o,
    input wire rprc_mode_e mode_o,
    input wire logic [EVENT_PINS-1:0] event_pin_o,
    input wire logic [EV_W-1:0] event_flags_o,
    input wire logic reply_start_o
);
    default clocking @(posedge sys_clk_i);
    endclocking
    default disable iff (sys_rst_i);
    wire logic take = ce_i && cmd_valid_i;
    wire logic query = take && cmd_i.op inside {CMD_PACKET_STATUS, CMD_BUFFER_STATUS, CMD_READ_REG};
    tx_done_a: assert property (ce_i && !take && mode_o == transmit_state && tx_last_bit_i
        |=> mode_o == rc_standby_state && event_flags_o[EV_TX_DONE]) else $error("tx end");
    rsp_on_a: assert property (query |=> rsp_valid_o) else $error("no answer");
    rsp_off_a: assert property (!query |=> !rsp_valid_o) else $error("stray answer");
    tx_start_a: assert property (take && cmd_i.op == CMD_START_TRANSMIT
        |=> mode_o == transmit_state) else $error("tx not entered");
    clear_keep_a: assert property (take && cmd_i.op == CMD_CLEAR_EVENTS
        |=> ($past(event_flags_o) & ~$past(cmd_i.arg[15:0]) & ~event_flags_o) == 0)
        else $error("unmasked flag lost");
    pin_or_a: assert property (event_pin_o != 0 |-> event_flags_o != 0) else $error("pin");
    fifo_room_a: assert property (!buf_valid_o |-> rx_data_ready_o) else $error("fifo room");
    reply_a: assert property (reply_start_o |-> $past(rng_req_valid_i)) else $error("reply");
endmodule
bind rprc_ctrl rprc_ctrl_assertions chk (.*);

//--- dv/rprc_host_model.sv
`timescale 1ns/1ps
module rprc_host_model
    import rprc_pkg::*;
(
    input wire logic sys_clk_i,
    output logic cmd_valid_o,
    output rprc_cmd_s cmd_o
);
    initial cmd_valid_o = 0;
    initial cmd_o = '0;
    task automatic send(input logic [3:0] op, input logic [31:0] arg);
        @(posedge sys_clk_i);
        cmd_valid_o <= 1;
        cmd_o <= {op, arg};
        @(posedge sys_clk_i);
        cmd_valid_o <= 0;
    endtask
endmodule

//--- dv/rprc_ctrl_test.sv
`timescale 1ns/1ps
module rprc_ctrl_test;
    import rprc_pkg::*;
    logic sys_clk_i = 0, sys_rst_i = 1, ce_i = 1, tick_i = 0, rx_data_valid_i = 0, buf_ready_i = 0;
    logic [10:0] ev = '0;
    logic [7:0] rx_data_i = '0, buf_data_o, d, fq[$];
    logic [31:0] rng_req_addr_i = '0, rsp_data_o, seed = 32'd14475, expq[$];
    rprc_rx_info_s rx_info_i = '0;
    logic cmd_valid_i, cmd_ready_o, rsp_valid_o, rx_data_ready_o, buf_valid_o, reply_start_o;
    rprc_cmd_s cmd_i;
    rprc_mode_e mode_o;
    logic [2:0] event_pin_o;
    logic [15:0] event_flags_o;
    logic [19:0] f, e;
    logic [23:0] carrier_freq_o, modulation_o;
    int fails = 0, check_count = 0, bits[8] = '{2, 3, 4, 5, 6, 10, 8, 9};
    rprc_ctrl dut (.*, .tx_last_bit_i(ev[0]), .rx_packet_i(ev[1]), .rx_sync_i(ev[2]),
        .rx_preamble_i(ev[3]), .rx_header_ok_i(ev[4]), .rx_header_bad_i(ev[5]),
        .rx_checksum_bad_i(ev[6]), .rng_req_valid_i(ev[7]), .init_result_ok_i(ev[8]),
        .init_timeout_i(ev[9]), .reply_done_i(ev[10]), .target_addr_o(), .range_cal_o(),
        .iq_invert_o(), .initiator_o());
    rprc_host_model host (.sys_clk_i, .cmd_valid_o(cmd_valid_i), .cmd_o(cmd_i));
    initial forever #5 sys_clk_i = ~sys_clk_i;
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic ask(input logic [3:0] op, input logic [31:0] arg, input logic [31:0] exp);
        expq.push_back(exp);
        host.send(op, arg);
    endtask
    task automatic pulse(input int b);
        @(posedge sys_clk_i);
        ev <= 11'(1) << b;
        @(posedge sys_clk_i);
        ev <= '0;
    endtask
    task automatic neg();
        @(negedge sys_clk_i);
    endtask
    task automatic summarize();
        if (fails == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    always @(negedge sys_clk_i)
        if (rsp_valid_o === 1'b1)
            chk(rsp_data_o, expq.size() > 0 ? expq.pop_front() : 32'hX);
    initial
    begin
        repeat (5000) @(posedge sys_clk_i);
        fails++;
        summarize();
    end
    initial
    begin
        repeat (2) @(posedge sys_clk_i);
        sys_rst_i <= 0;
        tick_i <= 1;
        for (int i = 0; i < 9; i++)
        begin
            d = 8'(rnd());
            f[11:0] = i < 8 ? 12'(REG_TARGET_ADDRESS_B3 + i) : REG_ADDRESS_MATCH_WIDTH;
            host.send(CMD_WRITE_REG, {4'h0, f[11:0], 8'h0, d});
            ask(CMD_READ_REG, {4'h0, f[11:0], 16'h0}, {24'h0, d});
        end
        host.send(CMD_WRITE_REG, {4'h0, REG_FREQ_ERROR_HIGH, 16'h00FF});
        ask(CMD_READ_REG, {4'h0, REG_FREQ_ERROR_HIGH, 16'h0}, 0);
        ask(CMD_READ_REG, 32'h09000000, 0);
        host.send(CMD_START_TRANSMIT, 0);
        neg();
        chk(mode_o, transmit_state);
        pulse(0);
        neg();
        chk({mode_o, event_flags_o}, {rc_standby_state, 16'h0001});
        host.send(CMD_START_TRANSMIT, 3);
        repeat (2) @(posedge sys_clk_i);
        neg();
        chk(mode_o, transmit_state);
        neg();
        chk({mode_o, event_flags_o}, {rc_standby_state, 16'h0081});
        host.send(CMD_CLEAR_EVENTS, 32'h0001);
        host.send(CMD_EVENT_ROUTING, 32'h0080);
        host.send(CMD_EVENT_ROUTING, 32'h00010080);
        neg();
        chk({event_pin_o, event_flags_o}, {3'h1, 16'h0080});
        host.send(CMD_CLEAR_EVENTS, 32'h0080);
        neg();
        chk(event_pin_o, 0);
        for (int q = 0; q < 2; q++)
        begin
            f = 20'(rnd());
            e = q ? -f : f;
            host.send(CMD_IQ_INVERT, q);
            host.send(CMD_START_RECEIVE, 0);
            rx_info_i <= '{8'hF4, f[7:0], f[15:8], f};
            repeat (4) neg();
            chk(mode_o, receive_state);
            pulse(1);
            neg();
            chk({mode_o, event_flags_o}, {rc_standby_state, 16'h0002});
            ask(CMD_PACKET_STATUS, 0, 32'hF4);
            ask(CMD_BUFFER_STATUS, 0, {16'h0, f[7:0], f[15:8]});
            for (int j = 0; j < 3; j++)
                ask(CMD_READ_REG, {4'h0, 12'(REG_FREQ_ERROR_HIGH + j), 16'h0},
                    ({12'h0, e} >> (16 - 8 * j)) & 255);
        end
        host.send(CMD_START_RECEIVE, 32'hFFFF);
        pulse(1);
        for (int k = 0; k < 8; k++)
        begin
            if (k == 6)
                host.send(CMD_START_TRANSMIT, 0);
            pulse(bits[k]);
            neg();
            chk({event_flags_o[bits[k]], mode_o}, {1'b1, k < 6 ? receive_state : transmit_state});
        end
        host.send(CMD_START_RECEIVE, 3);
        pulse(3);
        repeat (5) neg();
        chk(mode_o, receive_state);
        host.send(CMD_START_RECEIVE, 32'h00010001);
        repeat (4) @(posedge sys_clk_i);
        neg();
        chk({mode_o, event_flags_o[EV_TIMEOUT]}, {rc_standby_state, 1'b1});
        host.send(CMD_RANGING_ROLE, 0);
        host.send(CMD_WRITE_REG, {4'h0, REG_OWN_ADDRESS_B0, 16'h005A});
        host.send(CMD_START_RECEIVE, 32'hFFFF);
        for (int k = 0; k < 2; k++)
        begin
            host.send(CMD_WRITE_REG, {4'h0, REG_ADDRESS_MATCH_WIDTH, 8'h0, k ? 8'hC0 : 8'h00});
            rng_req_addr_i <= 32'h1234565A;
            pulse(7);
            neg();
            chk({reply_start_o, event_flags_o[EV_REJECT]}, k ? 1 : 2);
        end
        host.send(CMD_CARRIER_FREQ, 32'h00A5C3E1);
        host.send(CMD_MODULATION, 32'h00502601);
        neg();
        chk({carrier_freq_o, modulation_o[7:0]}, 32'hA5C3E101);
        for (int i = 0; i < 18; i++)
        begin
            @(posedge sys_clk_i);
            d = 8'(rnd());
            rx_data_valid_i <= i < 17;
            rx_data_i <= d;
            if (i < 16)
                fq.push_back(d);
        end
        neg();
        chk(rx_data_ready_o, 0);
        for (int i = 0; i < 16; i++)
        begin
            neg();
            chk(buf_data_o, fq.pop_front());
            @(posedge sys_clk_i) buf_ready_i <= 1;
            @(posedge sys_clk_i) buf_ready_i <= 0;
        end
        neg();
        chk({buf_valid_o, expq.size()}, 0);
        summarize();
    end
endmodule
